//--- src/deac_pkg.sv
// shared constants of the data storage access control block
// assumes a single 100 MHz clock and the plain register port of the top module
package deac_pkg;

	localparam int CLK_PERIOD_NS = 10;
	// programming time per byte; plain default, no figure is known for it
	localparam int WRITE_TIME_NS = 2560;
	localparam int WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WCNT_W        = 9;

	localparam int NVM_AW    = 7;
	localparam int NVM_DEPTH = 128;

	localparam logic [7:0] OFS_INTCTL_LO  = 8'h0b;
	localparam logic [7:0] OFS_INTCTL_HI  = 8'h8b;
	localparam logic [7:0] OFS_PIRQ_FLAGS = 8'h0c;
	localparam logic [7:0] OFS_PIRQ_EN    = 8'h8c;
	localparam logic [7:0] OFS_NVM_DATA   = 8'h9a;
	localparam logic [7:0] OFS_NVM_ADDR   = 8'h9b;
	localparam logic [7:0] OFS_NVM_CTRL   = 8'h9c;
	localparam logic [7:0] OFS_NVM_UNLOCK = 8'h9d;

	localparam int INT_GIE_BIT    = 7;
	localparam int INT_PERIPHERAL_IRQ_ENABLE_BIT   = 6;
	localparam int PIRQ_DONE_BIT  = 7;
	localparam int CTRL_WERR_BIT  = 3;
	localparam int CTRL_WRITE_ENABLE_GATE_BIT  = 2;
	localparam int CTRL_WR_BIT    = 1;
	localparam int CTRL_RD_BIT    = 0;

	localparam logic [7:0] PIRQ_MASK   = 8'hc9;
	localparam logic [7:0] INTCTL_KEEP = 8'h01;
	localparam logic [7:0] ZERO_BYTE   = 8'h00;

	// unlock keys: plain defaults
	localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

	typedef enum logic [1:0] {
		DEAC_UL_IDLE,
		DEAC_UL_KEY1,
		DEAC_UL_KEY2
	} deac_unlock_state_type;

endpackage : deac_pkg

//--- src/deac_store_if.sv
// signals between the access control and the storage array
// assumes both ends run on sys_clk
`timescale 1ns/10ps
interface deac_store_if;
	logic [deac_pkg::NVM_AW-1:0] addr;
	logic [7:0]                  wdata;
	logic [7:0]                  rdata;
	logic                        wr_start;
	logic                        abort;
	logic                        busy;
	logic                        done;

	modport ctrl  (output addr, wdata, wr_start, abort, input rdata, busy, done);
	modport store (input addr, wdata, wr_start, abort, output rdata, busy, done);
endinterface : deac_store_if

//--- src/deac_unlock.sv
// unlock sequence detector for the storage write start
// assumes one register write strobe per cycle at most
`timescale 1ns/10ps
module deac_unlock (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	input  wire logic       clear,
	input  wire logic       wr_strobe,
	input  wire logic       at_unlock,
	input  wire logic [7:0] wdata,
	output logic            unlocked
);
	typedef struct packed {
		deac_pkg::deac_unlock_state_type state;
	} deac_ul_type;

	deac_ul_type st_r;
	deac_ul_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (clear) begin
			st_nxt.state = deac_pkg::DEAC_UL_IDLE;
		end else if (wr_strobe) begin
			// any other write breaks the sequence
			case (st_r.state)
				deac_pkg::DEAC_UL_IDLE: begin
					if (at_unlock && wdata == deac_pkg::UNLOCK_KEY1)
						st_nxt.state = deac_pkg::DEAC_UL_KEY1;
				end
				deac_pkg::DEAC_UL_KEY1: begin
					if (at_unlock && wdata == deac_pkg::UNLOCK_KEY2)
						st_nxt.state = deac_pkg::DEAC_UL_KEY2;
					else
						st_nxt.state = deac_pkg::DEAC_UL_IDLE;
				end
				default: begin
					st_nxt.state = deac_pkg::DEAC_UL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			st_r <= '{state: deac_pkg::DEAC_UL_IDLE};
		else if (clk_en)
			st_r <= st_nxt;
	end

	assign unlocked = (st_r.state == deac_pkg::DEAC_UL_KEY2);

	a_unlock_order: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && st_r.state == deac_pkg::DEAC_UL_IDLE |=> st_r.state != deac_pkg::DEAC_UL_KEY2)
		else $error("unlock reached without first key");
endmodule : deac_unlock

//--- src/deac_store.sv
// 128 byte storage array with timed byte programming
// assumes start is only raised while not busy
`timescale 1ns/10ps
module deac_store (
	input  wire logic  sys_clk,
	input  wire logic  sys_rst,
	input  wire logic  clk_en,
	deac_store_if.store port
);
	typedef struct packed {
		logic                        busy;
		logic                        done;
		logic [deac_pkg::WCNT_W-1:0] cnt;
		logic [deac_pkg::NVM_AW-1:0] addr;
		logic [7:0]                  data;
	} deac_st_type;

	localparam logic [deac_pkg::WCNT_W-1:0] LAST = deac_pkg::WCNT_W'(deac_pkg::WRITE_CYCLES - 1);

	deac_st_type st_r;
	deac_st_type st_nxt;
	logic [7:0]  mem [deac_pkg::NVM_DEPTH];
	logic        commit;

	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		commit      = 1'b0;
		if (port.abort) begin
			st_nxt.busy = 1'b0;
		end else if (st_r.busy) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
			if (st_r.cnt == LAST) begin
				st_nxt.busy = 1'b0;
				st_nxt.done = 1'b1;
				commit      = 1'b1;
			end
		end else if (port.wr_start) begin
			st_nxt.busy = 1'b1;
			st_nxt.cnt  = '0;
			st_nxt.addr = port.addr;
			st_nxt.data = port.wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			st_r <= '0;
		else if (clk_en)
			st_r <= st_nxt;
	end

	always_ff @(posedge sys_clk) begin
		if (!sys_rst && clk_en && commit)
			mem[st_r.addr] <= st_r.data;
	end

	assign port.rdata = mem[port.addr];
	assign port.busy  = st_r.busy;
	assign port.done  = st_r.done;

	a_start_busy: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && port.wr_start && !port.abort && !st_r.busy |=> st_r.busy)
		else $error("write start did not begin programming");
endmodule : deac_store

//--- src/deac_top.sv
// data storage access control: registers, strobes, unlock, error and done flag
// assumes a plain register port, one strobe per cycle, and reset pulses
// from the core's reset logic synchronous to sys_clk
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
module deac_top (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	input  wire logic       ext_reset_pulse,
	input  wire logic       wdt_reset_pulse,
	input  wire logic       core_sleep,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_we,
	input  wire logic       reg_re,
	output logic      [7:0] reg_rdata,
	output logic            irq
);
	typedef struct packed {
		logic [7:0] intctl;
		logic [7:0] pirq_flags;
		logic [7:0] pirq_en;
		logic       werr;
		logic       write_enable_gate;
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] data;
		logic [7:0] rdata;
		logic       irq;
	} deac_top_type;

	deac_top_type st_r;
	deac_top_type st_nxt;

	logic       other_rst;
	logic       unlocked;
	logic       wr_go;
	logic [7:0] ctrl_view;
	logic       at_unlock;

	deac_store_if nvm_if ();

	// a watchdog timeout while asleep only wakes the core
	assign other_rst = ext_reset_pulse | (wdt_reset_pulse & ~core_sleep);
	assign at_unlock = (reg_addr == deac_pkg::OFS_NVM_UNLOCK);

	deac_unlock u_unlock (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.clear     (other_rst),
		.wr_strobe (reg_we),
		.at_unlock (at_unlock),
		.wdata     (reg_wdata),
		.unlocked  (unlocked)
	);

	deac_store u_store (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.port    (nvm_if.store)
	);

	always_comb begin
		ctrl_view = deac_pkg::ZERO_BYTE;
		ctrl_view[deac_pkg::CTRL_WERR_BIT] = st_r.werr;
		ctrl_view[deac_pkg::CTRL_WRITE_ENABLE_GATE_BIT] = st_r.write_enable_gate;
		ctrl_view[deac_pkg::CTRL_WR_BIT]   = st_r.wr;
		ctrl_view[deac_pkg::CTRL_RD_BIT]   = st_r.rd;
	end

	// write start needs enable already set, the key pair just before, and no write running
	assign wr_go = reg_we && reg_addr == deac_pkg::OFS_NVM_CTRL
		&& reg_wdata[deac_pkg::CTRL_WR_BIT] && st_r.write_enable_gate && unlocked && !st_r.wr;

	assign nvm_if.addr     = st_r.addr[deac_pkg::NVM_AW-1:0];
	assign nvm_if.wdata    = st_r.data;
	assign nvm_if.wr_start = wr_go;
	assign nvm_if.abort    = other_rst;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.rdata = deac_pkg::ZERO_BYTE;

		// read completes one cycle after its strobe was set
		if (st_r.rd) begin
			st_nxt.data = nvm_if.rdata;
			st_nxt.rd   = 1'b0;
		end

		if (reg_re) begin
			case (reg_addr)
				deac_pkg::OFS_INTCTL_LO,
				deac_pkg::OFS_INTCTL_HI: st_nxt.rdata = st_r.intctl;
				deac_pkg::OFS_PIRQ_FLAGS: begin
					st_nxt.rdata = st_r.pirq_flags;
					// reading the flags acknowledges the done event
					st_nxt.pirq_flags[deac_pkg::PIRQ_DONE_BIT] = 1'b0;
				end
				deac_pkg::OFS_PIRQ_EN:    st_nxt.rdata = st_r.pirq_en;
				deac_pkg::OFS_NVM_DATA:   st_nxt.rdata = st_r.data;
				deac_pkg::OFS_NVM_ADDR:   st_nxt.rdata = st_r.addr;
				deac_pkg::OFS_NVM_CTRL:   st_nxt.rdata = ctrl_view;
				deac_pkg::OFS_NVM_UNLOCK: st_nxt.rdata = deac_pkg::ZERO_BYTE;
				default:                  st_nxt.rdata = deac_pkg::ZERO_BYTE;
			endcase
		end

		if (reg_we) begin
			case (reg_addr)
				deac_pkg::OFS_INTCTL_LO,
				deac_pkg::OFS_INTCTL_HI: st_nxt.intctl = reg_wdata;
				deac_pkg::OFS_PIRQ_FLAGS: begin
					st_nxt.pirq_flags = reg_wdata & deac_pkg::PIRQ_MASK;
				end
				deac_pkg::OFS_PIRQ_EN: st_nxt.pirq_en = reg_wdata & deac_pkg::PIRQ_MASK;
				deac_pkg::OFS_NVM_DATA: st_nxt.data = reg_wdata;
				deac_pkg::OFS_NVM_ADDR: st_nxt.addr = reg_wdata;
				deac_pkg::OFS_NVM_CTRL: begin
					st_nxt.werr = reg_wdata[deac_pkg::CTRL_WERR_BIT];
					st_nxt.write_enable_gate = reg_wdata[deac_pkg::CTRL_WRITE_ENABLE_GATE_BIT];
					// strobes only set; a zero written leaves them alone
					if (reg_wdata[deac_pkg::CTRL_RD_BIT])
						st_nxt.rd = 1'b1;
					if (wr_go)
						st_nxt.wr = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// hardware events after software so that a done or reset event wins over a register access
		if (nvm_if.done) begin
			st_nxt.wr   = 1'b0;
			st_nxt.werr = 1'b0;
			st_nxt.pirq_flags[deac_pkg::PIRQ_DONE_BIT] = 1'b1;
		end

		if (other_rst) begin
			if (st_r.wr && !nvm_if.done)
				st_nxt.werr = 1'b1;
			st_nxt.wr         = 1'b0;
			st_nxt.rd         = 1'b0;
			st_nxt.write_enable_gate       = 1'b0;
			st_nxt.addr       = deac_pkg::ZERO_BYTE;
			st_nxt.data       = deac_pkg::ZERO_BYTE;
			st_nxt.intctl     = st_r.intctl & deac_pkg::INTCTL_KEEP;
			st_nxt.pirq_flags = deac_pkg::ZERO_BYTE;
			st_nxt.pirq_en    = deac_pkg::ZERO_BYTE;
			st_nxt.rdata      = deac_pkg::ZERO_BYTE;
		end

		// level request taken from the next state so it tracks the flags exactly
		st_nxt.irq = st_nxt.pirq_flags[deac_pkg::PIRQ_DONE_BIT]
			&& st_nxt.pirq_en[deac_pkg::PIRQ_DONE_BIT]
			&& st_nxt.intctl[deac_pkg::INT_PERIPHERAL_IRQ_ENABLE_BIT]
			&& st_nxt.intctl[deac_pkg::INT_GIE_BIT];
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			st_r <= '0;
		else if (clk_en)
			st_r <= st_nxt;
	end

	assign reg_rdata = st_r.rdata;
	assign irq       = st_r.irq;

	a_ctrl_upper_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && reg_re && reg_addr == deac_pkg::OFS_NVM_CTRL |=> reg_rdata[7:4] == 4'h0)
		else $error("control upper bits not zero");

	a_unlock_reads_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && reg_re && at_unlock |=> reg_rdata == 8'h00)
		else $error("unlock port read not zero");

	a_read_one_cycle: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && st_r.rd && !(reg_we && reg_addr == deac_pkg::OFS_NVM_CTRL
			&& reg_wdata[deac_pkg::CTRL_RD_BIT]) |=> !st_r.rd)
		else $error("read strobe held past one cycle");

	a_read_data_lands: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && st_r.rd && !reg_we && !other_rst |=> st_r.data == $past(nvm_if.rdata))
		else $error("read byte not in data register");

	a_write_held: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && st_r.wr && !nvm_if.done && !other_rst |=> st_r.wr)
		else $error("write strobe dropped before completion");

	a_write_enable_gate_gates_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && !st_r.wr && !st_r.write_enable_gate |=> !st_r.wr)
		else $error("write started without enable");

	a_unlock_needed: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && !st_r.wr && !unlocked |=> !st_r.wr && !nvm_if.busy)
		else $error("write started without unlock");

	a_abort_error: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && st_r.wr && other_rst && !nvm_if.done |=> st_r.werr && !nvm_if.busy)
		else $error("aborted write did not flag error");

	a_abort_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && other_rst |=> st_r.addr == 8'h00 && st_r.data == 8'h00)
		else $error("reset left address or data");

	a_done_sets_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && nvm_if.done && !other_rst |=> st_r.pirq_flags[7] && !st_r.wr)
		else $error("write completion flag not set");

	a_done_clears_err: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && nvm_if.done && !other_rst |=> !st_r.werr)
		else $error("error flag set after normal write");

	a_irq_gated: assert property (@(posedge sys_clk) disable iff (sys_rst)
		irq |-> st_r.pirq_flags[7] && st_r.pirq_en[7] && st_r.intctl[7] && st_r.intctl[6])
		else $error("interrupt without all enables");

	a_addr_msb_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
		nvm_if.addr == st_r.addr[6:0])
		else $error("storage address not low seven bits");

	a_write_span: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && wr_go && !other_rst |=> st_r.wr && nvm_if.busy)
		else $error("write start not taken");
endmodule : deac_top

//--- bench/deac_top_tb_top.sv
// self-checking bench for the data storage access control block
// assumes deac_pkg is compiled first; drives the register port and reset events directly
`timescale 1ns/10ps
module deac_top_tb_top;

	logic       sys_clk;
	logic       sys_rst;
	logic       clk_en;
	logic       ext_reset_pulse;
	logic       wdt_reset_pulse;
	logic       core_sleep;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_we;
	logic       reg_re;
	logic [7:0] reg_rdata;
	logic       irq;
	int         miscompares;
	int         samples_checked;
	logic [31:0] lfsr;

	deac_top dut (
		.sys_clk         (sys_clk),
		.sys_rst         (sys_rst),
		.clk_en          (clk_en),
		.ext_reset_pulse (ext_reset_pulse),
		.wdt_reset_pulse (wdt_reset_pulse),
		.core_sleep      (core_sleep),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_we          (reg_we),
		.reg_re          (reg_re),
		.reg_rdata       (reg_rdata),
		.irq             (irq)
	);

	always #5 sys_clk = ~sys_clk;

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	// expected control byte: upper nibble never implemented
	function automatic logic [7:0] exp_ctrl(input logic err, input logic write_enable_gate, input logic wr);
		return {4'h0, err, write_enable_gate, wr, 1'b0};
	endfunction : exp_ctrl

	task automatic end_sim;
		$display("checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_we    <= 1'b1;
		@(posedge sys_clk);
		reg_we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_re   <= 1'b1;
		@(posedge sys_clk);
		reg_re <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		chk(v, exp);
	endtask : rdchk

	task automatic nvm_write(input logic [7:0] a, input logic [7:0] d);
		wr(deac_pkg::OFS_NVM_ADDR, {1'b0, a[6:0]});
		wr(deac_pkg::OFS_NVM_DATA, d);
		wr(deac_pkg::OFS_NVM_CTRL, 8'h04);
		wr(deac_pkg::OFS_NVM_UNLOCK, deac_pkg::UNLOCK_KEY1);
		wr(deac_pkg::OFS_NVM_UNLOCK, deac_pkg::UNLOCK_KEY2);
		wr(deac_pkg::OFS_NVM_CTRL, 8'h06);
	endtask : nvm_write

	// polls the strobe; a write that never ends counts as a mismatch
	task automatic wait_done;
		logic [7:0] v;
		int         i;
		for (i = 0; i < 400; i++) begin
			rd(deac_pkg::OFS_NVM_CTRL, v);
			if (v[1] === 1'b0) begin
				break;
			end
		end
		if (i == 400) begin
			chk(v, 8'h04);
		end
	endtask : wait_done

	task automatic readback(input logic [7:0] a, input logic [7:0] d);
		wr(deac_pkg::OFS_NVM_ADDR, a ^ 8'h80);
		// keep write enable set so the read strobe is the only change
		wr(deac_pkg::OFS_NVM_CTRL, 8'h05);
		rdchk(deac_pkg::OFS_NVM_CTRL, 8'h04);
		rdchk(deac_pkg::OFS_NVM_DATA, d);
	endtask : readback

	task automatic pulse(input int src);
		@(posedge sys_clk);
		ext_reset_pulse <= (src == 0);
		wdt_reset_pulse <= (src != 0);
		@(posedge sys_clk);
		ext_reset_pulse <= 1'b0;
		wdt_reset_pulse <= 1'b0;
	endtask : pulse

	initial begin
		// nine programmed writes plus polling and register traffic, with margin
		repeat (40 * deac_pkg::WRITE_CYCLES) @(posedge sys_clk);
		miscompares++;
		end_sim();
	end

	initial begin
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] ofs[9];
		sys_clk = 1'b0;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		ext_reset_pulse = 1'b0;
		wdt_reset_pulse = 1'b0;
		core_sleep = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_we = 1'b0;
		reg_re = 1'b0;
		miscompares = 0;
		samples_checked = 0;
		lfsr = 32'hb3f85305;
		ofs = '{8'h0b, 8'h8b, 8'h0c, 8'h8c, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h20};
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		foreach (ofs[i]) begin
			rdchk(ofs[i], 8'h00);
		end
		$display("reset values done");
		wr(deac_pkg::OFS_NVM_CTRL, 8'hf4);
		rdchk(deac_pkg::OFS_NVM_CTRL, exp_ctrl(1'b0, 1'b1, 1'b0));
		wr(deac_pkg::OFS_NVM_UNLOCK, 8'h3c);
		rdchk(deac_pkg::OFS_NVM_UNLOCK, 8'h00);
		wr(deac_pkg::OFS_NVM_CTRL, 8'h06);
		rdchk(deac_pkg::OFS_NVM_CTRL, exp_ctrl(1'b0, 1'b1, 1'b0));
		wr(deac_pkg::OFS_NVM_CTRL, 8'h00);
		wr(deac_pkg::OFS_NVM_UNLOCK, deac_pkg::UNLOCK_KEY1);
		wr(deac_pkg::OFS_NVM_UNLOCK, deac_pkg::UNLOCK_KEY2);
		wr(deac_pkg::OFS_NVM_CTRL, 8'h02);
		rdchk(deac_pkg::OFS_NVM_CTRL, 8'h00);
		$display("write gating done");
		for (int k = 0; k < 4; k++) begin
			lfsr = lfsr_next(lfsr);
			a = lfsr[7:0];
			d = lfsr[15:8];
			wr(deac_pkg::OFS_INTCTL_LO, 8'hc0);
			wr(deac_pkg::OFS_PIRQ_EN, {k[0], 7'h00});
			nvm_write(a, d);
			wr(deac_pkg::OFS_NVM_CTRL, 8'h04);
			rdchk(deac_pkg::OFS_NVM_CTRL, exp_ctrl(1'b0, 1'b1, 1'b1));
			wait_done();
			rdchk(deac_pkg::OFS_NVM_CTRL, exp_ctrl(1'b0, 1'b1, 1'b0));
			chk({7'h00, irq}, {7'h00, k[0]});
			rdchk(deac_pkg::OFS_PIRQ_FLAGS, 8'h80);
			@(posedge sys_clk);
			#1;
			chk({7'h00, irq}, 8'h00);
			readback(a, d);
		end
		$display("random writes done");
		// source 2 is a watchdog event while asleep, which must not abort
		for (int src = 0; src < 3; src++) begin
			lfsr = lfsr_next(lfsr);
			a = lfsr[7:0];
			d = lfsr[15:8];
			core_sleep <= (src == 2);
			nvm_write(a, d);
			repeat (20) @(posedge sys_clk);
			pulse(src);
			core_sleep <= 1'b0;
			rdchk(deac_pkg::OFS_NVM_CTRL, exp_ctrl(src != 2, src == 2, src == 2));
			if (src != 2) begin
				rdchk(deac_pkg::OFS_NVM_ADDR, 8'h00);
				rdchk(deac_pkg::OFS_NVM_DATA, 8'h00);
				rdchk(deac_pkg::OFS_PIRQ_FLAGS, 8'h00);
				wr(deac_pkg::OFS_NVM_CTRL, 8'h00);
				nvm_write(a, d);
			end
			wait_done();
			rdchk(deac_pkg::OFS_NVM_CTRL, exp_ctrl(1'b0, 1'b1, 1'b0));
			readback(a, d);
		end
		// last write left the done flag set; software clears it by a write
		wr(deac_pkg::OFS_PIRQ_FLAGS, 8'h00);
		rdchk(deac_pkg::OFS_PIRQ_FLAGS, 8'h00);
		$display("aborted writes done");
		end_sim();
	end

endmodule : deac_top_tb_top
